// ### design/ssp_top.sv
// Synchronous serial shift port with its registers, serial clock and shift engine.
`timescale 1ns/10ps
module ssp_top
   import ssp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic serial_data_in_pin,
   output logic serial_data_out_pin,
   output logic serial_data_out_oe,
   output logic xfer_done
);
   logic wr_en;
   logic [1:0] wr_sel;
   logic [7:0] wr_byte;
   logic rd_en;
   logic [1:0] rd_sel;
   logic [7:0] rd_byte;

   logic [7:0] ctrl_reg;
   logic overrun_reg;
   logic overrun_armed_reg;
   logic spare_reg;
   logic [7:0] data_up_reg;
   logic [7:0] data_lo_reg;
   ssp_xfer_e state_reg;
   logic [4:0] bit_cnt_reg;
   logic done_seen_reg;
   logic prev_clk_reg;

   logic [1:0] pin_vec;
   logic [1:0] sync_a_reg;
   logic [1:0] sync_b_reg;
   logic [1:0] sync_c_reg;
   logic [1:0] filt_reg;

   logic [1:0] mode;
   logic src_ext;
   logic mode_xfer;
   logic ctrl_wr;
   logic stat_wr;
   logic up_wr;
   logic lo_wr;
   logic stat_rd;
   logic start_go;
   logic pre_clear;
   logic pre_level;
   logic ser_clk;
   logic clk_fall;
   logic clk_rise;
   logic last_bit;
   logic [4:0] xfer_len;
   logic overrun_set;
   logic overrun_clr;
   logic busy;
   logic [7:0] stat_view;

   ssp_axil_slave u_bus (
      .clk(clk),
      .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_sel(wr_sel),
      .wr_byte(wr_byte),
      .rd_en(rd_en),
      .rd_sel(rd_sel),
      .rd_byte(rd_byte)
   );

   // Register strobes and control fields.
   assign mode = ctrl_reg[CTRL_MODE_MSB:CTRL_MODE_LSB];
   assign src_ext = ctrl_reg[CTRL_SRC];
   assign mode_xfer = (mode == MODE_8BIT) || (mode == MODE_16BIT);
   assign ctrl_wr = wr_en && (wr_sel == SEL_MODE_CLK);
   assign stat_wr = wr_en && (wr_sel == SEL_CTRL_STAT);
   assign up_wr = wr_en && (wr_sel == SEL_DATA_UP);
   assign lo_wr = wr_en && (wr_sel == SEL_DATA_LO);
   assign stat_rd = rd_en && (rd_sel == SEL_CTRL_STAT);
   assign busy = (state_reg == XFER_RUN);

   // A start is taken only from idle in a transfer mode; a written 0 does nothing.
   assign start_go = stat_wr && wr_byte[STAT_START] && mode_xfer && !busy;

   // The prescaler restarts on each start so the first edge is a falling one.
   assign pre_clear = ctrl_wr || start_go;

   ssp_prescaler u_pre (
      .clk(clk),
      .rst_b(rst_b),
      .clear(pre_clear),
      .div_sel(ctrl_reg[CTRL_DIV_MSB:0]),
      .div_level(pre_level)
   );

   // Pin inputs pass three flops; a level counts once the last two agree.
   assign pin_vec[PIN_SCK] = sck_in;
   assign pin_vec[PIN_SDI] = serial_data_in_pin;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin_sync
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               sync_a_reg[gi] <= 1'b1;
               sync_b_reg[gi] <= 1'b1;
               sync_c_reg[gi] <= 1'b1;
               filt_reg[gi] <= 1'b1;
            end else begin
               sync_a_reg[gi] <= pin_vec[gi];
               sync_b_reg[gi] <= sync_a_reg[gi];
               sync_c_reg[gi] <= sync_b_reg[gi];
               if (sync_b_reg[gi] == sync_c_reg[gi]) begin
                  filt_reg[gi] <= sync_c_reg[gi];
               end
            end
         end
      end
   endgenerate

   // Serial clock source and its edges.
   assign ser_clk = src_ext ? filt_reg[PIN_SCK] : pre_level;
   assign clk_fall = prev_clk_reg && !ser_clk;
   assign clk_rise = !prev_clk_reg && ser_clk;
   assign xfer_len = (mode == MODE_16BIT) ? LEN_16BIT : LEN_8BIT;
   assign last_bit = (bit_cnt_reg + 5'h01) == xfer_len;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prev_clk_reg <= 1'b1;
      end else if (start_go && !src_ext) begin
         // The restarted prescaler comes up high, so an old low level must not read as a rise.
         prev_clk_reg <= 1'b1;
      end else begin
         prev_clk_reg <= ser_clk;
      end
   end

   // Control register: all eight bits store, including the two spare ones.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_reg <= CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_reg <= wr_byte;
      end
   end

   // Transfer state machine.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= XFER_IDLE;
         bit_cnt_reg <= 5'h00;
      end else if (ctrl_wr) begin
         state_reg <= XFER_IDLE;
         bit_cnt_reg <= 5'h00;
      end else begin
         case (state_reg)
            XFER_IDLE: begin
               if (start_go) begin
                  state_reg <= XFER_RUN;
                  bit_cnt_reg <= 5'h00;
               end
            end
            XFER_RUN: begin
               if (clk_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (last_bit) begin
                     state_reg <= XFER_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= XFER_IDLE;
            end
         endcase
      end
   end

   // Completion pulse, one clock long.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= busy && clk_rise && last_bit && !ctrl_wr;
      end
   end

   // Shift registers: received bits enter at the MSB of the top byte in 16-bit mode, of the low byte in 8-bit mode.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         data_up_reg <= DATA_RST;
         data_lo_reg <= DATA_RST;
      end else if (busy && clk_rise && !ctrl_wr) begin
         if (mode == MODE_16BIT) begin
            data_up_reg <= {filt_reg[PIN_SDI], data_up_reg[7:1]};
            data_lo_reg <= {data_up_reg[0], data_lo_reg[7:1]};
         end else begin
            data_lo_reg <= {filt_reg[PIN_SDI], data_lo_reg[7:1]};
         end
      end else begin
         if (up_wr) begin
            data_up_reg <= wr_byte;
         end
         if (lo_wr) begin
            data_lo_reg <= wr_byte;
         end
      end
   end

   // Data output: a written level holds until the first falling edge shifts data.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         serial_data_out_pin <= 1'b0;
      end else if (busy && clk_fall && !ctrl_wr) begin
         serial_data_out_pin <= data_lo_reg[0];
      end else if (stat_wr) begin
         serial_data_out_pin <= wr_byte[STAT_LEVEL];
      end
      // Otherwise the last shifted bit or written level stays on the pin.
   end

   // Pin drivers follow mode and clock source.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         serial_data_out_oe <= 1'b1;
         sck_oe <= 1'b1;
         sck_out <= 1'b1;
      end else begin
         serial_data_out_oe <= (mode != MODE_CONT);
         sck_oe <= !src_ext;
         if (src_ext) begin
            sck_out <= 1'b1;
         end else if (mode == MODE_CONT) begin
            sck_out <= pre_level;
         end else if (busy && !start_go) begin
            sck_out <= pre_level;
         end else begin
            sck_out <= 1'b1;
         end
      end
   end

   // Overrun: an external clock pulse after a completed transfer.
   assign overrun_set = src_ext && mode_xfer && !busy && done_seen_reg && clk_fall;
   assign overrun_clr = stat_wr && !wr_byte[STAT_OVERRUN] && overrun_armed_reg;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         done_seen_reg <= 1'b0;
      end else if (ctrl_wr || start_go) begin
         done_seen_reg <= 1'b0;
      end else if (busy && clk_rise && last_bit) begin
         done_seen_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overrun_reg <= STAT_RST[STAT_OVERRUN];
      end else if (overrun_set) begin
         overrun_reg <= 1'b1;
      end else if (overrun_clr) begin
         overrun_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overrun_armed_reg <= 1'b0;
      end else if (overrun_clr) begin
         overrun_armed_reg <= 1'b0;
      end else if (stat_rd && overrun_reg) begin
         overrun_armed_reg <= 1'b1;
      end
   end

   // Spare status bit stores what is written.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         spare_reg <= STAT_RST[STAT_SPARE];
      end else if (stat_wr) begin
         spare_reg <= wr_byte[STAT_SPARE];
      end
   end

   // Status view: fixed one on top, fixed zeros in the middle.
   always_comb begin
      stat_view = STAT_RST;
      stat_view[STAT_LEVEL] = serial_data_out_pin;
      stat_view[STAT_OVERRUN] = overrun_reg;
      stat_view[STAT_SPARE] = spare_reg;
      stat_view[STAT_START] = busy;
   end

   always_comb begin
      case (rd_sel)
         SEL_MODE_CLK: rd_byte = ctrl_reg;
         SEL_CTRL_STAT: rd_byte = stat_view;
         SEL_DATA_UP: rd_byte = data_up_reg;
         SEL_DATA_LO: rd_byte = data_lo_reg;
         default: rd_byte = 8'h00;
      endcase
   end
endmodule // ssp_top

// ### inc/ssp_pkg.sv
// Constants, types and decode helpers for the synchronous serial shift port.
package ssp_pkg;
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_MODE_CLK = 16'hFFA0;
   localparam logic [15:0] IDX_CTRL_STAT = 16'hFFA1;
   localparam logic [15:0] IDX_DATA_UP = 16'hFFA2;
   localparam logic [15:0] IDX_DATA_LO = 16'hFFA3;
   localparam logic [17:0] ADDR_MODE_CLK = {IDX_MODE_CLK, 2'b00};
   localparam logic [17:0] ADDR_CTRL_STAT = {IDX_CTRL_STAT, 2'b00};
   localparam logic [17:0] ADDR_DATA_UP = {IDX_DATA_UP, 2'b00};
   localparam logic [17:0] ADDR_DATA_LO = {IDX_DATA_LO, 2'b00};
   localparam logic [1:0] SEL_MODE_CLK = 2'h0;
   localparam logic [1:0] SEL_CTRL_STAT = 2'h1;
   localparam logic [1:0] SEL_DATA_UP = 2'h2;
   localparam logic [1:0] SEL_DATA_LO = 2'h3;
   localparam int CTRL_MODE_MSB = 7;
   localparam int CTRL_MODE_LSB = 6;
   localparam int CTRL_SRC = 3;
   localparam int CTRL_DIV_MSB = 2;
   localparam int STAT_ONE = 7;
   localparam int STAT_LEVEL = 6;
   localparam int STAT_OVERRUN = 5;
   localparam int STAT_SPARE = 1;
   localparam int STAT_START = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h80;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [1:0] MODE_8BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_CONT = 2'h2;
   localparam logic [4:0] LEN_8BIT = 5'h08;
   localparam logic [4:0] LEN_16BIT = 5'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int PIN_SCK = 1;
   localparam int PIN_SDI = 0;

   typedef enum logic {XFER_IDLE, XFER_RUN} ssp_xfer_e;

   // Counter bit whose period matches the selected division.
   function automatic logic [3:0] ssp_div_tap(input logic [2:0] sel);
      case (sel)
         3'h0: ssp_div_tap = 4'h9;
         3'h1: ssp_div_tap = 4'h7;
         3'h2: ssp_div_tap = 4'h5;
         3'h3: ssp_div_tap = 4'h4;
         3'h4: ssp_div_tap = 4'h3;
         3'h5: ssp_div_tap = 4'h2;
         3'h6: ssp_div_tap = 4'h1;
         default: ssp_div_tap = 4'h0;
      endcase
   endfunction

   // Returns 1 when the byte address hits one of the four registers.
   function automatic logic ssp_addr_hit(input logic [17:0] addr);
      ssp_addr_hit = (addr == ADDR_MODE_CLK) || (addr == ADDR_CTRL_STAT) ||
                     (addr == ADDR_DATA_UP) || (addr == ADDR_DATA_LO);
   endfunction
endpackage

// ### design/ssp_prescaler.sv
// Free running prescaler that produces the selected divided serial clock level.
`timescale 1ns/10ps
module ssp_prescaler
   import ssp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic [2:0] div_sel,
   output logic div_level
);
   logic [9:0] count_reg;

   // Restarting from zero makes the level start high, so a falling edge comes first.
   always_ff @(posedge clk) begin
      if (!rst_b || clear) begin
         count_reg <= 10'h000;
      end else begin
         count_reg <= count_reg + 10'h001;
      end
   end

   assign div_level = ~count_reg[ssp_div_tap(div_sel)];
endmodule // ssp_prescaler

// ### design/ssp_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/10ps
module ssp_axil_slave
   import ssp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [17:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [1:0] wr_sel,
   output logic [7:0] wr_byte,
   output logic rd_en,
   output logic [1:0] rd_sel,
   input wire logic [7:0] rd_byte
);
   logic [17:0] aw_addr_reg;
   logic [17:0] ar_addr_reg;
   logic [7:0] w_byte_reg;
   logic w_lane0_reg;
   logic rd_pend_reg;
   logic wr_go;

   // Both halves captured and no response pending: perform the write now.
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_en = wr_go && ssp_addr_hit(aw_addr_reg) && w_lane0_reg;
   assign wr_sel = aw_addr_reg[3:2];
   assign wr_byte = w_byte_reg;
   assign rd_en = rd_pend_reg && ssp_addr_hit(ar_addr_reg);
   assign rd_sel = ar_addr_reg[3:2];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_addr_reg <= 18'h00000;
         w_byte_reg <= 8'h00;
         w_lane0_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte_reg <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= ssp_addr_hit(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         ar_addr_reg <= 18'h00000;
         rd_pend_reg <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_addr_reg <= s_axi_araddr;
            s_axi_arready <= 1'b0;
            rd_pend_reg <= 1'b1;
         end
         if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (ssp_addr_hit(ar_addr_reg)) begin
               s_axi_rdata <= {24'h000000, rd_byte};
               s_axi_rresp <= RESP_OKAY;
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // ssp_axil_slave

// ### testbench/ssp_top_monitor.sv
// Concurrent checks on the serial port outputs.
`timescale 1ns/10ps
module ssp_top_monitor
   import ssp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [17:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic serial_data_out_pin,
   input wire logic serial_data_out_oe,
   input wire logic xfer_done
);
   logic sck_q, sck_qq, bv_q, fell, fell_q, st_rd, bad_rd;
   logic [4:0] nf;
   logic [17:0] ra_q;
   assign fell = sck_q && !sck_out;
   assign fell_q = sck_qq && !sck_q;
   assign st_rd = ra_q == ADDR_CTRL_STAT;
   assign bad_rd = ra_q[17:4] != 14'h3FE8 || ra_q[1:0] != 2'h0;
   always_ff @(posedge clk) begin
      sck_q <= sck_out;
      sck_qq <= sck_q;
      bv_q <= s_axi_bvalid;
   end
   always_ff @(posedge clk) begin
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
   end
   // Counts driven clock falls since the last register write.
   always_ff @(posedge clk) begin
      if (!rst_b || (s_axi_bvalid && !bv_q)) nf <= 5'h00;
      else if (fell && sck_oe) nf <= nf + 5'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_done_one; xfer_done |=> !xfer_done; endproperty
   a_done_one: assert property (p_done_one) else $error("done pulse too long");
   property p_done_cnt; xfer_done && sck_oe |-> nf == 5'h08 || nf == 5'h10; endproperty
   a_done_cnt: assert property (p_done_cnt) else $error("bad clock count");
   property p_quiet; xfer_done && sck_oe |-> sck_out ##1 $stable(sck_out) [*3]; endproperty
   a_quiet: assert property (p_quiet) else $error("clock after done");
   property p_tx_edge;
      $changed(serial_data_out_pin) && serial_data_out_oe && sck_oe && !(s_axi_bvalid && !bv_q)
         |-> fell || fell_q;
   endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("data moved off a fall");
   property p_cont; !serial_data_out_oe |-> !xfer_done; endproperty
   a_cont: assert property (p_cont) else $error("transfer in clock mode");
   property p_rd_stat;
      $rose(s_axi_rvalid) && st_rd |-> s_axi_rdata[7] && s_axi_rdata[4:2] == 3'h0;
   endproperty
   a_rd_stat: assert property (p_rd_stat) else $error("status fixed bits wrong");
   property p_rd_lvl;
      $rose(s_axi_rvalid) && st_rd && $stable(serial_data_out_pin) &&
         serial_data_out_pin == $past(serial_data_out_pin, 2)
         |-> s_axi_rdata[6] == serial_data_out_pin;
   endproperty
   a_rd_lvl: assert property (p_rd_lvl) else $error("level bit not pin");
   property p_bad_rd;
      $rose(s_axi_rvalid) && bad_rd |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_bad_rd: assert property (p_bad_rd) else $error("unmapped read answered");
endmodule // ssp_top_monitor

bind ssp_top ssp_top_monitor u_mon (.*);

// ### testbench/ssp_peer_model.sv
// Link partner that drives data and an external clock and captures output data.
`timescale 1ns/10ps
module ssp_peer_model (
   input wire logic clk,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic serial_data_out_pin,
   input wire logic arm,
   input wire logic ext_go,
   input wire logic [4:0] ext_n,
   input wire logic [15:0] tx_word,
   output logic sck_in,
   output logic serial_data_in_pin,
   output logic [15:0] rx_word
);
   logic sck_w;
   int idx;
   assign sck_w = sck_oe ? sck_out : sck_in;
   initial begin
      sck_in = 1'h1;
      serial_data_in_pin = 1'h0;
      rx_word = 16'h0000;
      idx = 0;
   end
   always @(posedge arm) idx <= 0;
   // Sends LSB first on falls and captures on rises.
   always @(negedge sck_w) begin
      if (idx < 16) serial_data_in_pin <= tx_word[idx];
      idx <= idx + 1;
   end
   always @(posedge sck_w) rx_word <= {serial_data_out_pin, rx_word[15:1]};
   // External clock pulses, five system clocks per phase.
   always @(posedge ext_go) begin
      repeat (ext_n) begin
         repeat (5) @(posedge clk);
         sck_in <= 1'h0;
         repeat (5) @(posedge clk);
         sck_in <= 1'h1;
      end
   end
endmodule // ssp_peer_model

// ### testbench/sync_serial_shift_port_tb.sv
// Self-checking bench for the serial shift port.
`timescale 1ns/10ps
module sync_serial_shift_port_tb
   import ssp_pkg::*;
;
   localparam logic [17:0] CT = ADDR_MODE_CLK, ST = ADDR_CTRL_STAT;
   localparam logic [17:0] UP = ADDR_DATA_UP, LO = ADDR_DATA_LO;
   logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic sck_in, sck_out, sck_oe, serial_data_in_pin, serial_data_out_pin;
   logic serial_data_out_oe, xfer_done, arm, ext_go, sck_d;
   logic [4:0] ext_n;
   logic [15:0] tx_word, rx_word;
   int errors = 0, checks = 0, falls = 0, dones = 0, cyc = 0, lastf = 0, per = 0;
   int dv [8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
   ssp_top dut (.*);
   ssp_peer_model peer (.*);
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      sck_d <= sck_out;
      cyc <= cyc + 1;
      if (xfer_done === 1'h1) dones <= dones + 1;
      if (sck_d === 1'h1 && sck_out === 1'h0) begin
         falls <= falls + 1;
         per <= cyc - lastf;
         lastf <= cyc;
      end
   end
   task automatic stop_test();
      if (errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 1000);
      s_axi_bready <= 1'h0;
      chk({31'h0, s_axi_bvalid, s_axi_bresp}, {31'h0, 1'b1, r});
      @(posedge clk);
   endtask
   task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [1:0] r = RESP_OKAY);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 1000);
      s_axi_rready <= 1'h0;
      chk(s_axi_rvalid, 1);
      chk({s_axi_rresp, s_axi_rdata}, {r, 24'h000000, e});
      @(posedge clk);
   endtask
   task automatic wait_done();
      int n, d0;
      n = 0;
      d0 = dones;
      while (dones == d0 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk(dones - d0, 1);
   endtask
   task automatic run(input logic [7:0] c, u, l, input logic [15:0] tx, input int nb);
      int f0;
      wr(CT, c);
      wr(UP, u);
      wr(LO, l);
      tx_word <= tx;
      arm <= 1'h1;
      wr(ST, 8'h40);
      chk(serial_data_out_pin, 1);
      arm <= 1'h0;
      f0 = falls;
      wr(ST, 8'h41);
      wait_done();
      chk(falls - f0, nb);
   endtask
   initial begin
      int d0, f0;
      rst_b = 1'h0;
      s_axi_wstrb = 4'h1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {arm, ext_go, ext_n, tx_word} = '0;
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      rd(CT, 8'h00);
      rd(ST, 8'h80);
      rd(18'h00010, 8'h00, RESP_SLVERR);
      wr(18'h00010, 8'h55, RESP_SLVERR);
      wr(CT, 8'h30);
      rd(CT, 8'h30);
      wr(ST, 8'h9C);
      rd(ST, 8'h80);
      chk(dones, 0);
      for (int k = 0; k < 8; k++) begin
         run({5'h00, 3'(k)}, 8'h00, 8'h5A, 16'h00C3, 8);
         chk(per, dv[k]);
         chk(serial_data_out_pin, 0);
         rd(ST, 8'h80);
         if (k < 5) begin
            chk(rx_word[15:8], 8'h5A);
            rd(LO, 8'hC3);
         end
      end
      run(8'h44, 8'h96, 8'h5A, 16'h1234, 16);
      chk(rx_word, 16'h965A);
      rd(UP, 8'h12);
      rd(LO, 8'h34);
      rd(ST, 8'hC0);
      wr(CT, 8'h00);
      wr(ST, 8'h41);
      rd(ST, 8'hC1);
      wr(CT, 8'h00);
      rd(ST, 8'hC0);
      d0 = dones;
      f0 = falls;
      repeat (1200) @(posedge clk);
      chk(dones - d0, 0);
      chk(falls - f0, 0);
      wr(CT, 8'h87);
      wr(ST, 8'h01);
      repeat (20) @(posedge clk);
      chk(falls - f0 > 8, 1);
      chk(serial_data_out_oe, 0);
      chk(dones - d0, 0);
      wr(CT, 8'h08);
      wr(LO, 8'h00);
      chk(sck_oe, 0);
      tx_word <= 16'h00A7;
      arm <= 1'h1;
      wr(ST, 8'h01);
      arm <= 1'h0;
      ext_n <= 5'h08;
      ext_go <= 1'h1;
      wait_done();
      ext_go <= 1'h0;
      rd(LO, 8'hA7);
      rd(ST, 8'h80);
      ext_n <= 5'h01;
      ext_go <= 1'h1;
      repeat (20) @(posedge clk);
      ext_go <= 1'h0;
      rd(ST, 8'hA0);
      wr(ST, 8'h20);
      rd(ST, 8'hA0);
      wr(ST, 8'h00);
      rd(ST, 8'h80);
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      stop_test();
   end
endmodule // sync_serial_shift_port_tb
